// [nrfa_pkg.sv]
// Purpose: Shared constants and types for the nibble register file access block.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Attribute codes describe each control word's access behaviour.
package nrfa_pkg;

  // ==========================================================================
  // Geometry
  localparam int NRFA_ADDR_W = 7;
  localparam int NRFA_NIB_W = 4;
  localparam int NRFA_CTRL_WORDS = 64;
  localparam int NRFA_BANK_W = 4;
  localparam logic [6:0] NRFA_CTRL_LO = 7'h00;
  localparam logic [6:0] NRFA_CTRL_HI = 7'h3F;
  localparam logic [6:0] NRFA_DMEM_LO = 7'h40;
  localparam logic [6:0] NRFA_DMEM_HI = 7'h7F;
  localparam logic [6:0] NRFA_WINDOW_ADDR = 7'h78;
  localparam int NRFA_UPPER_BIT = 6;

  // ==========================================================================
  // Reset values and fill value
  localparam logic [3:0] NRFA_WINDOW_RESET = 4'h0;
  localparam logic [3:0] NRFA_CTRL_RESET = 4'h0;
  localparam logic [3:0] NRFA_UNDEF_NIB = 4'hF;

  // ==========================================================================
  // Access attributes
  typedef enum logic [2:0] {
    NRFA_ATTR_UNUSED = 3'h0,
    NRFA_ATTR_RW = 3'h1,
    NRFA_ATTR_RO = 3'h2,
    NRFA_ATTR_WO = 3'h3,
    NRFA_ATTR_RORST = 3'h4
  } nrfa_attr_t;

  // Per-word configuration: attribute, writable-bit mask, read-as-zero mask.
  typedef struct packed {
    nrfa_attr_t attr;
    logic [3:0] live_mask;
    logic [3:0] rdz_mask;
  } nrfa_word_cfg_t;

  // Transfer request from the core.
  typedef struct packed {
    logic read_req;
    logic write_req;
    logic [6:0] addr;
  } nrfa_xfer_t;

  // Data memory port toward the shared storage.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] bank;
    logic [5:0] addr;
    logic [3:0] wdata;
  } nrfa_dmem_req_t;

  // ==========================================================================
  // Core state machine
  typedef enum logic [1:0] {
    NRFA_ST_IDLE = 2'b00,
    NRFA_ST_DMEM = 2'b01,
    NRFA_ST_DONE = 2'b11
  } nrfa_state_t;

endpackage : nrfa_pkg

// [nrfa_ctrl_words.sv]
// Purpose: Storage for the 64 peripheral control words with per-word attributes.
// Assumes: Attribute table is fixed per model at elaboration.
// Notes: Reads are combinational; writes and reset-on-read clears are clocked.
`timescale 1ns/1ps
module nrfa_ctrl_words
  import nrfa_pkg::*;
#(
  parameter nrfa_word_cfg_t CFG [NRFA_CTRL_WORDS] = '{default: '{NRFA_ATTR_RW, 4'hF, 4'h0}}
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Access
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [5:0] addr_i,
  input wire logic [3:0] wdata_i,
  output logic [3:0] rdata_o,
  // Peripheral side
  output logic [NRFA_CTRL_WORDS*4-1:0] words_o,
  input wire logic [NRFA_CTRL_WORDS*4-1:0] status_i
);

  logic [3:0] word [NRFA_CTRL_WORDS];
  logic [3:0] next_word [NRFA_CTRL_WORDS];
  nrfa_word_cfg_t cur;

  // ==========================================================================
  // Read path
  always_comb
  begin
    cur = CFG[addr_i];
    case (cur.attr)
      NRFA_ATTR_RW:
        rdata_o = word[addr_i] & ~cur.rdz_mask & cur.live_mask;
      NRFA_ATTR_RO, NRFA_ATTR_RORST:
        rdata_o = status_i[addr_i*4 +: 4] & cur.live_mask | word[addr_i] & cur.live_mask;
      NRFA_ATTR_WO:
        rdata_o = NRFA_UNDEF_NIB;
      default:
        rdata_o = NRFA_UNDEF_NIB;
    endcase
  end

  // ==========================================================================
  // Update path
  always_comb
  begin
    for (int i = 0; i < NRFA_CTRL_WORDS; i++)
    begin
      next_word[i] = word[i];
      words_o[i*4 +: 4] = word[i] & CFG[i].live_mask;
      // Reset-on-read words catch status events so a short pulse is still seen at the next read.
      if (CFG[i].attr == NRFA_ATTR_RORST)
      begin
        next_word[i] = word[i] | (status_i[i*4 +: 4] & CFG[i].live_mask);
      end
    end
    if (wr_i && (CFG[addr_i].attr == NRFA_ATTR_RW || CFG[addr_i].attr == NRFA_ATTR_WO))
    begin
      next_word[addr_i] = wdata_i & CFG[addr_i].live_mask;
    end
    if (rd_i && CFG[addr_i].attr == NRFA_ATTR_RORST)
    begin
      // An event landing in the read cycle wins over the clear, so no event is lost.
      next_word[addr_i] = NRFA_CTRL_RESET | (status_i[addr_i*4 +: 4] & CFG[addr_i].live_mask);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NRFA_CTRL_WORDS; i++)
      begin
        word[i] <= NRFA_CTRL_RESET;
      end
    end
    else
    begin
      word <= next_word;
    end
  end

endmodule : nrfa_ctrl_words

// [nrfa_top.sv]
// Purpose: Nibble register file access between the core window register and the file.
// Assumes: Core holds a transfer request until done_o; data memory answers in the same cycle that rd is high.
// Notes: Upper half is the data memory of the bank selected when the transfer starts.
//
// Operation
// - Register file holds 128 four-bit entries with a seven-bit address.
// - Addresses 00H to 3FH select peripheral control words.
// - Addresses 40H to 7FH map to data memory in the selected bank.
// - Every transfer passes through the four-bit window register at 78H.
// - File read instruction copies the addressed entry into the window register.
// - File write instruction copies the window into the entry, per its attribute.
// - Upper half also stays reachable by ordinary data memory instructions.
// - Each control word has one attribute: RW, RO, WO or reset-on-read.
// - Some read/write flags read zero although writes take effect.
// - Writes to read-only words, including reset-on-read, change nothing.
// - Reading a write-only word returns an undefined nibble.
// - Hard-wired zero bits read zero and stay zero on writes.
// - Unused control addresses read undefined and ignore writes.
// - Implemented control words are a model parameter; others act unused.
`timescale 1ns/1ps
module nrfa_top
  import nrfa_pkg::*;
#(
  parameter nrfa_word_cfg_t CFG [NRFA_CTRL_WORDS] = '{default: '{NRFA_ATTR_RW, 4'hF, 4'h0}}
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Core transfer request
  input wire nrfa_xfer_t xfer_i,
  input wire logic [3:0] bank_i,
  output logic busy_o,
  output logic done_o,
  // Core access to the window register as a system register
  input wire logic win_wr_i,
  input wire logic [3:0] win_wdata_i,
  output logic [3:0] window_o,
  // Data memory port
  output nrfa_dmem_req_t dmem_o,
  input wire logic [3:0] dmem_rdata_i,
  // Peripherals
  output logic [NRFA_CTRL_WORDS*4-1:0] ctrl_words_o,
  input wire logic [NRFA_CTRL_WORDS*4-1:0] ctrl_status_i
);

  // ==========================================================================
  // State
  nrfa_state_t state;
  nrfa_state_t next_state;
  logic [3:0] window_transfer_register;
  logic [3:0] next_window;
  nrfa_dmem_req_t next_dmem;
  logic [3:0] ctrl_rdata;
  logic ctrl_rd;
  logic ctrl_wr;
  logic start;

  function automatic logic is_upper(input logic [6:0] a);
    is_upper = a[NRFA_UPPER_BIT];
  endfunction : is_upper

  assign start = (state == NRFA_ST_IDLE) && (xfer_i.read_req || xfer_i.write_req);
  // Control words act in the request cycle so a reset-on-read clear is single-shot.
  assign ctrl_rd = start && xfer_i.read_req && !is_upper(xfer_i.addr);
  assign ctrl_wr = start && xfer_i.write_req && !xfer_i.read_req && !is_upper(xfer_i.addr);

  nrfa_ctrl_words #(
    .CFG(CFG)
  ) u_ctrl (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .rd_i(ctrl_rd),
    .wr_i(ctrl_wr),
    .addr_i(xfer_i.addr[5:0]),
    .wdata_i(window_transfer_register),
    .rdata_o(ctrl_rdata),
    .words_o(ctrl_words_o),
    .status_i(ctrl_status_i)
  );

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    next_state = state;
    next_window = window_transfer_register;
    next_dmem = '0;
    case (state)
      NRFA_ST_IDLE:
      begin
        if (start && is_upper(xfer_i.addr))
        begin
          next_dmem.rd = xfer_i.read_req;
          next_dmem.wr = !xfer_i.read_req;
          next_dmem.bank = bank_i;
          next_dmem.addr = xfer_i.addr[5:0];
          next_dmem.wdata = window_transfer_register;
          next_state = xfer_i.read_req ? NRFA_ST_DMEM : NRFA_ST_DONE;
        end
        else if (start)
        begin
          if (xfer_i.read_req)
          begin
            next_window = ctrl_rdata;
          end
          next_state = NRFA_ST_DONE;
        end
        else if (win_wr_i)
        begin
          next_window = win_wdata_i;
        end
      end
      NRFA_ST_DMEM:
      begin
        next_window = dmem_rdata_i;
        next_state = NRFA_ST_DONE;
      end
      NRFA_ST_DONE:
      begin
        next_state = NRFA_ST_IDLE;
      end
      default:
      begin
        next_state = NRFA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= NRFA_ST_IDLE;
      window_transfer_register <= NRFA_WINDOW_RESET;
      dmem_o <= '0;
    end
    else
    begin
      state <= next_state;
      window_transfer_register <= next_window;
      dmem_o <= next_dmem;
    end
  end

  assign busy_o = (state != NRFA_ST_IDLE);
  assign done_o = (state == NRFA_ST_DONE);
  assign window_o = window_transfer_register;

endmodule : nrfa_top

// [nrfa_chk.sv]
// Purpose: Port checks for nrfa_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module nrfa_chk
  import nrfa_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Core
  input wire nrfa_xfer_t xfer_i,
  input wire logic [3:0] bank_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic win_wr_i,
  input wire logic [3:0] win_wdata_i,
  input wire logic [3:0] window_o,
  // Memory
  input wire nrfa_dmem_req_t dmem_o,
  input wire logic [3:0] dmem_rdata_i
);
  // ==========================================================================
  // Checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic go;
  logic up;
  assign go = !busy_o && (xfer_i.read_req || xfer_i.write_req);
  assign up = xfer_i.addr[6];
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_take_busy: assert property (go |=> busy_o)
    else $error("not taken");
  a_ctrl_quick: assert property (go && !up |=> done_o && !dmem_o.rd && !dmem_o.wr)
    else $error("ctrl timing");
  a_upper_read: assert property (go && xfer_i.read_req && up |=> dmem_o.rd && !done_o
    && dmem_o.addr == $past(xfer_i.addr[5:0]) && dmem_o.bank == $past(bank_i) ##1 done_o)
    else $error("upper read");
  a_upper_write: assert property (go && !xfer_i.read_req && up |=> dmem_o.wr && done_o
    && dmem_o.wdata == $past(window_o))
    else $error("upper write");
  a_read_data: assert property (dmem_o.rd |=> window_o == $past(dmem_rdata_i))
    else $error("read data");
  a_win_load: assert property (!busy_o && win_wr_i && !go |=> window_o == $past(win_wdata_i))
    else $error("window load");
  a_write_keeps: assert property (go && !xfer_i.read_req |=> $stable(window_o))
    else $error("window moved");
endmodule : nrfa_chk

// [nrfa_dmem_model.sv]
// Purpose: Data memory behind the block.
// Assumes: Read data valid while rd is high and one cycle on.
// Notes: Outside that, the inverse of the last value shows.
`timescale 1ns/1ps
module nrfa_dmem_model
  import nrfa_pkg::*;
(
  // Port
  input wire logic clk_i,
  input wire nrfa_dmem_req_t dmem_i,
  output logic [3:0] rdata_o
);
  // ==========================================================================
  // Storage
  logic [3:0] mem [1024];
  logic [3:0] last;
  logic held;
  logic [9:0] idx;
  assign idx = {dmem_i.bank, dmem_i.addr};
  assign rdata_o = dmem_i.rd ? mem[idx] : (held ? last : ~last);
  always @(posedge clk_i)
  begin
    if (dmem_i.wr) mem[idx] <= dmem_i.wdata;
    if (dmem_i.rd) last <= mem[idx];
    held <= dmem_i.rd;
  end
endmodule : nrfa_dmem_model

// [test_nibble_register_file_access.sv]
// Purpose: Self-checking bench for nrfa_top.
// Assumes: Undefined nibbles read as F.
// Notes: Words 0 to 6 cover each attribute.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; $display("ERROR %s exp %h got %h", n, e, a); end end
module test_nibble_register_file_access
  import nrfa_pkg::*;
;
  // ==========================================================================
  // Setup
  localparam nrfa_word_cfg_t CFG [NRFA_CTRL_WORDS] = '{0: '{NRFA_ATTR_RW, 4'hF, 4'h0},
    1: '{NRFA_ATTR_RO, 4'hF, 4'h0}, 2: '{NRFA_ATTR_WO, 4'hF, 4'h0}, 3: '{NRFA_ATTR_RORST, 4'hF, 4'h0},
    5: '{NRFA_ATTR_RW, 4'h7, 4'h0}, 6: '{NRFA_ATTR_RW, 4'hF, 4'h1}, default: '{NRFA_ATTR_UNUSED, 4'h0, 4'h0}};
  localparam logic [3:0] RD_EXP [7] = '{4'hF, 4'h6, 4'hF, 4'h0, 4'hF, 4'h7, 4'hE};
  localparam logic [3:0] OUT_EXP [7] = '{4'hF, 4'h0, 4'hF, 4'h0, 4'h0, 4'h7, 4'hF};
  logic clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  nrfa_xfer_t xfer_i = '0;
  logic [3:0] bank_i = 4'h0;
  logic win_wr_i = 1'h0;
  logic [3:0] win_wdata_i = 4'h0;
  logic [255:0] ctrl_status_i = 256'h60;
  logic busy_o, done_o;
  logic [3:0] window_o, dmem_rdata_i;
  nrfa_dmem_req_t dmem_o;
  logic [255:0] ctrl_words_o;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  nrfa_top #(.CFG(CFG)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .xfer_i(xfer_i), .bank_i(bank_i),
    .busy_o(busy_o), .done_o(done_o), .win_wr_i(win_wr_i), .win_wdata_i(win_wdata_i), .window_o(window_o),
    .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata_i), .ctrl_words_o(ctrl_words_o), .ctrl_status_i(ctrl_status_i));
  nrfa_dmem_model u_mem (.clk_i(clk_i), .dmem_i(dmem_o), .rdata_o(dmem_rdata_i));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000) begin err_count++; complete_run(); end
  end
  task automatic win(input logic [3:0] d);
    @(posedge clk_i);
    win_wr_i <= 1'h1;
    win_wdata_i <= d;
    @(posedge clk_i);
    win_wr_i <= 1'h0;
  endtask : win
  // The request is held until done is seen, as the core must.
  task automatic xfer(input logic r, input logic w, input logic [6:0] a, input logic [3:0] b);
    int n;
    @(posedge clk_i);
    xfer_i <= '{r, w, a};
    bank_i <= b;
    n = 0;
    do begin @(posedge clk_i); n++; end while (done_o !== 1'h1 && n < 10);
    xfer_i <= '0;
    `CHK("done", 1'h1, done_o)
    `CHK("busy", 1'h1, busy_o)
  endtask : xfer
  task automatic t_ctrl();
    for (int i = 0; i < 7; i++)
    begin
      win(4'hF);
      xfer(1'h0, 1'h1, 7'(i), 4'h0);
      win(4'h0);
      xfer(1'h1, 1'h0, 7'(i), 4'h0);
      `CHK("read", RD_EXP[i], window_o)
      `CHK("word", OUT_EXP[i], ctrl_words_o[i*4 +: 4])
    end
    $display("control test done");
  endtask : t_ctrl
  task automatic t_upper();
    win(4'h5);
    xfer(1'h0, 1'h1, 7'h45, 4'h3);
    // The model stores on the edge that ends the transfer, so look one edge later.
    @(posedge clk_i);
    `CHK("mem", 4'h5, u_mem.mem[{4'h3, 6'h05}])
    u_mem.mem[{4'h2, 6'h05}] = 4'hC;
    win(4'h0);
    xfer(1'h1, 1'h0, 7'h45, 4'h2);
    `CHK("upper", 4'hC, window_o)
    $display("upper test done");
  endtask : t_upper
  task automatic t_rorst();
    @(posedge clk_i);
    ctrl_status_i[15:12] <= 4'h9;
    @(posedge clk_i);
    ctrl_status_i[15:12] <= 4'h0;
    xfer(1'h1, 1'h0, 7'h03, 4'h0);
    `CHK("rorst", 4'h9, window_o)
    xfer(1'h1, 1'h0, 7'h03, 4'h0);
    `CHK("rorst clear", 4'h0, window_o)
    $display("reset-on-read test done");
  endtask : t_rorst
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'h1;
    t_ctrl();
    t_upper();
    t_rorst();
    complete_run();
  end
endmodule : test_nibble_register_file_access
bind nrfa_top nrfa_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .xfer_i(xfer_i), .bank_i(bank_i),
  .busy_o(busy_o), .done_o(done_o), .win_wr_i(win_wr_i), .win_wdata_i(win_wdata_i), .window_o(window_o),
  .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata_i));
